// [design/qspm_core.sv]
// Purpose: queued serial port, master and slave, with 16-entry ram queue
// Assumes: control bits are static while enabled, except queue pointers
// Notes:   all pins pass three-stage sync; pin outputs other than the clock lag one clock
//
// How it works
// RL1: ram holds 16 command, transmit, receive entries
// RL2: load pointer, run, record completed, increment
// RL3: end match sets finished, stops unless wrap
// RL4: start and end pointers reset to zero
// RL5: start write redirects after current transfer
// RL6: zero start and end gives one transfer
// RL7: master select picks queue master or slave
// RL8: slave drives no chip selects, auto-advances
// RL9: select input in master sets mode fault
// RL10: software arbitrates, disables port after fault
// RL11: phase and polarity pick drive, latch edges
// RL12: msb first, eight to sixteen bits
// RL13: open drain makes all pins wired-or
// RL14: serial clock is clock over twice divider
// RL15: divider below two holds clock idle
// RL16: delay bit waits delay field clocks
// RL17: no delay bit waits half clock period
// RL18: length bit picks default or length field
// RL19: length code zero is sixteen, 1xxx eight-fifteen
// RL20: master drives clock and mosi, samples miso
// RL21: software fills queue before enabling master
// RL22: receive word right-justified, upper bits zero
// RL23: irq follows finished flag when enabled
// RL24: entry copied before shifting starts

module qspm_core
  import qspm_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  // configuration
  input  wire logic        I_PORT_ENABLE,
  input  wire logic        I_MASTER_SELECT,
  input  wire logic        I_CLOCK_PHASE_SELECT,
  input  wire logic        I_CLOCK_POLARITY_SELECT,
  input  wire logic        I_OPEN_DRAIN_SELECT,
  input  wire logic        I_WRAP_ENABLE,
  input  wire logic        I_QUEUE_FINISHED_IRQ_ENABLE,
  input  wire logic [7:0]  I_BAUD_DIVIDER,
  input  wire logic [3:0]  I_LENGTH_FIELD,
  input  wire logic [6:0]  I_CS_TO_CLOCK_DELAY,
  // queue pointer writes and flag clear
  input  wire logic        I_START_PTR_WE,
  input  wire logic [3:0]  I_QUEUE_START_POINTER,
  input  wire logic        I_END_PTR_WE,
  input  wire logic [3:0]  I_QUEUE_END_POINTER,
  input  wire logic        I_FLAG_CLEAR,
  // ram access
  input  wire logic        I_RAM_WE,
  input  wire logic [1:0]  I_RAM_SEL,
  input  wire logic [3:0]  I_RAM_INDEX,
  input  wire logic [15:0] I_RAM_WDATA,
  output logic      [15:0] O_RAM_RDATA,
  // status
  output logic      [3:0]  O_QUEUE_START_POINTER,
  output logic      [3:0]  O_QUEUE_END_POINTER,
  output logic      [3:0]  O_COMPLETED_ENTRY_POINTER,
  output logic             O_QUEUE_FINISHED_FLAG,
  output logic             O_MODE_FAULT_FLAG,
  output logic             O_IRQ,
  output logic             O_BUSY,
  // serial pins
  input  wire logic        I_SCK_IN,
  output logic             O_SCK_OUT,
  output logic             O_SCK_OE,
  input  wire logic        I_MOSI_IN,
  output logic             O_MOSI_OUT,
  output logic             O_MOSI_OE,
  input  wire logic        I_MISO_IN,
  output logic             O_MISO_OUT,
  output logic             O_MISO_OE,
  input  wire logic        I_SLAVE_SELECT_N,
  output logic      [3:0]  O_PCS_OUT,
  output logic      [3:0]  O_PCS_OE
);

  // whole block state
  typedef struct packed {
    qspm_state_t                   st;
    logic [QDEPTH-1:0][CMD_W-1:0]  cmd;
    logic [QDEPTH-1:0][WORD_W-1:0] tx;
    logic [QDEPTH-1:0][WORD_W-1:0] rx;
    logic [PTR_W-1:0]              start_ptr;
    logic [PTR_W-1:0]              end_ptr;
    logic [PTR_W-1:0]              wptr;
    logic [PTR_W-1:0]              cpt;
    logic                          pend;
    logic                          fin;
    logic                          mode_fault_flag;
    logic                          irq;
    logic                          busy;
    logic [CMD_W-1:0]              cur_cmd;
    logic [WORD_W-1:0]             tx_word;
    logic [WORD_W-1:0]             rx_word;
    logic [4:0]                    len;
    logic [3:0]                    bit_idx;
    logic [5:0]                    edge_cnt;
    logic [7:0]                    cnt;
    logic                          sck_lvl;
    logic                          sck_prev;
    logic [WORD_W-1:0]             rdata;
    logic [6:0]                    pin_out;
    logic [6:0]                    pin_oe;
  } qspm_regs_t;

  qspm_regs_t q;  // registered state
  qspm_regs_t d;  // next state

  // filtered pins
  logic [3:0] filt;
  logic       sck_f;
  logic       mosi_f;
  logic       miso_f;
  logic       ssn_f;

  // pin synchroniser, select idles high
  qspm_pin_sync #(
    .W   (4),
    .RST (4'hF)
  ) u_sync (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_pin    ({I_SCK_IN, I_MOSI_IN, I_MISO_IN, I_SLAVE_SELECT_N}),
    .o_filt   (filt)
  );

  assign {sck_f, mosi_f, miso_f, ssn_f} = filt;

  // combinational helpers
  logic       master;     // enabled as master
  logic       slv_sel;    // enabled slave, selected
  logic       ev;         // one serial clock edge
  logic       lead;       // edge is the leading one
  logic [7:0] lead_tgt;   // clocks before first edge
  logic [6:0] val;        // pin values before open drain
  logic [6:0] oe;         // pin enables before open drain
  logic       rx_bit;     // incoming data bit

  // next-state logic
  always_comb begin
    d        = q;
    master   = I_PORT_ENABLE && I_MASTER_SELECT;
    slv_sel  = I_PORT_ENABLE && !I_MASTER_SELECT && !ssn_f;
    ev       = 1'b0;
    lead     = !q.edge_cnt[0];
    rx_bit   = I_MASTER_SELECT ? miso_f : mosi_f;
    lead_tgt = I_BAUD_DIVIDER;
    d.sck_prev = sck_f;

    // RL1 software ram writes
    if (I_RAM_WE && I_RAM_SEL == SEG_CMD) begin
      d.cmd[I_RAM_INDEX] = I_RAM_WDATA[CMD_W-1:0];
    end else if (I_RAM_WE && I_RAM_SEL == SEG_TX) begin
      d.tx[I_RAM_INDEX] = I_RAM_WDATA;
    end
    // registered read port
    unique case (I_RAM_SEL)
      SEG_CMD: d.rdata = {8'h00, q.cmd[I_RAM_INDEX]};
      SEG_TX:  d.rdata = q.tx[I_RAM_INDEX];
      SEG_RX:  d.rdata = q.rx[I_RAM_INDEX];
      default: d.rdata = 16'h0000;
    endcase

    // RL5 start write redirects
    if (I_START_PTR_WE) begin
      d.start_ptr = I_QUEUE_START_POINTER;
      if (q.st == ST_IDLE || q.st == ST_STOP) begin
        d.wptr = I_QUEUE_START_POINTER;
      end else begin
        d.pend = 1'b1;
      end
    end
    if (I_END_PTR_WE) begin
      d.end_ptr = I_QUEUE_END_POINTER;
    end

    // flag clear, any set below wins
    if (I_FLAG_CLEAR) begin
      d.fin  = 1'b0;
      d.mode_fault_flag = 1'b0;
    end
    // RL9 select while master faults
    if (master && !ssn_f) begin
      d.mode_fault_flag = 1'b1;
    end

    // edge source: baud tick or slave clock
    if (q.st == ST_SHIFT) begin
      if (I_MASTER_SELECT) begin
        // RL14 modulus baud counter
        if (I_BAUD_DIVIDER >= BAUD_MIN) begin
          if (q.cnt >= I_BAUD_DIVIDER - 8'h01) begin
            d.cnt = 8'h00;
            ev    = 1'b1;
          end else begin
            d.cnt = q.cnt + 8'h01;
          end
        end
      end else begin
        ev = (sck_f != q.sck_prev);
      end
    end

    // sequencer
    unique case (q.st)
      ST_IDLE: begin
        d.sck_lvl = I_CLOCK_POLARITY_SELECT;
        // RL7 master runs, slave waits select
        if (master || slv_sel) begin
          d.st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // RL24 copy entry before shifting
        d.cur_cmd = q.cmd[q.wptr];
        d.tx_word = q.tx[q.wptr];
        d.rx_word = '0;
        // RL18 default or programmed length
        if (I_MASTER_SELECT && !q.cmd[q.wptr][CMD_LEN_SEL]) begin
          d.len = LEN_DEFAULT;
        end else begin
          // RL19 length code decode
          d.len = qspm_len_decode(I_LENGTH_FIELD);
        end
        d.bit_idx  = d.len[3:0] - 4'h1;
        d.edge_cnt = '0;
        d.cnt      = 8'h00;
        d.st       = I_MASTER_SELECT ? ST_LEAD : ST_SHIFT;
      end
      ST_LEAD: begin
        // RL16 programmed select-to-clock delay
        if (q.cur_cmd[CMD_DLY_SEL]) begin
          lead_tgt = {1'b0, (I_CS_TO_CLOCK_DELAY < DLY_MIN) ? DLY_MIN
                                                             : I_CS_TO_CLOCK_DELAY};
          // RL17 half period delay
        end else if (I_BAUD_DIVIDER < BAUD_MIN) begin
          // RL15 stalled, clock held idle
          lead_tgt = 8'hFF;
        end
        if (q.cnt + 8'h01 >= lead_tgt && lead_tgt != 8'hFF) begin
          // preload so the first edge falls in the first shift cycle
          d.cnt = I_BAUD_DIVIDER - 8'h01;
          d.st  = ST_SHIFT;
        end else if (lead_tgt != 8'hFF) begin
          d.cnt = q.cnt + 8'h01;
        end
      end
      ST_SHIFT: begin
        if (!I_MASTER_SELECT && ssn_f) begin
          // early deselect, same entry next time
          d.st = ST_IDLE;
        end else if (ev) begin
          // RL11 phase picks latch edge
          if (lead ^ I_CLOCK_PHASE_SELECT) begin
            d.rx_word[q.bit_idx] = rx_bit;
          // RL12 msb first, step down
          end else if (q.edge_cnt != '0 && q.bit_idx != 4'h0) begin
            d.bit_idx = q.bit_idx - 4'h1;
          end
          if (I_MASTER_SELECT) begin
            d.sck_lvl = !q.sck_lvl;
          end
          d.edge_cnt = q.edge_cnt + 6'h01;
          if (q.edge_cnt == {q.len, 1'b0} - 6'h01) begin
            d.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // RL22 right-justified receive word
        d.rx[q.wptr] = q.rx_word;
        // RL2 record completed, advance
        d.cpt  = q.wptr;
        d.wptr = q.pend ? q.start_ptr : q.wptr + 4'h1;
        d.pend = 1'b0;
        d.st   = I_MASTER_SELECT ? ST_LOAD : ST_IDLE;
        // RL3 RL6 end of queue
        if (q.wptr == q.end_ptr) begin
          d.fin  = 1'b1;
          d.wptr = q.start_ptr;
          if (!I_WRAP_ENABLE) begin
            d.st = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        d.sck_lvl = I_CLOCK_POLARITY_SELECT;
      end
      default: d.st = ST_IDLE;
    endcase

    // disabling the port stops everything
    if (!I_PORT_ENABLE) begin
      d.st      = ST_IDLE;
      d.sck_lvl = I_CLOCK_POLARITY_SELECT;
    end

    // RL23 interrupt follows flag
    d.irq  = d.fin && I_QUEUE_FINISHED_IRQ_ENABLE;
    d.busy = (d.st != ST_IDLE) && (d.st != ST_STOP);

    // RL20 master drives clock, mosi
    // clock pin comes from next state, so it lags one flop less than the selects
    val[0] = d.sck_lvl;
    oe[0]  = master;
    val[1] = q.tx_word[q.bit_idx];
    oe[1]  = master;
    // slave answers on miso when selected
    val[2] = q.tx_word[q.bit_idx];
    oe[2]  = slv_sel;
    // RL8 chip selects only in master
    val[6:3] = (q.st == ST_LEAD || q.st == ST_SHIFT || q.st == ST_DONE)
               ? q.cur_cmd[CMD_PCS_LSB +: CMD_PCS_W] : PCS_IDLE;
    oe[6:3]  = {CMD_PCS_W{master}};
    // RL13 wired-or open drain
    if (I_OPEN_DRAIN_SELECT) begin
      d.pin_out = '0;
      d.pin_oe  = oe & ~val;
    end else begin
      d.pin_out = val;
      d.pin_oe  = oe;
    end
  end

  // RL4 state register, pointers reset zero
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      q <= qspm_regs_t'('0);
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign O_RAM_RDATA               = q.rdata;
  assign O_QUEUE_START_POINTER     = q.start_ptr;
  assign O_QUEUE_END_POINTER       = q.end_ptr;
  assign O_COMPLETED_ENTRY_POINTER = q.cpt;
  assign O_QUEUE_FINISHED_FLAG     = q.fin;
  assign O_MODE_FAULT_FLAG         = q.mode_fault_flag;
  assign O_IRQ                     = q.irq;
  assign O_BUSY                    = q.busy;
  assign {O_PCS_OUT, O_MISO_OUT, O_MOSI_OUT, O_SCK_OUT} = q.pin_out;
  assign {O_PCS_OE, O_MISO_OE, O_MOSI_OE, O_SCK_OE}     = q.pin_oe;

  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  chk_ptr_reset: assert property ( // RL4
    @(posedge I_CLK) disable iff (1'b0)
    !I_RESETN |=> (q.start_ptr == 4'h0 && q.end_ptr == 4'h0 && q.wptr == 4'h0))
    else $error("pointers not zero after reset");

  chk_cpt_copy: assert property ( // RL2
    q.st == ST_DONE |=> (q.cpt == $past(q.wptr) && q.st != ST_DONE))
    else $error("completed pointer not copied");

  chk_finish_set: assert property ( // RL3
    (q.st == ST_DONE && q.wptr == q.end_ptr && !I_WRAP_ENABLE && I_PORT_ENABLE)
    |=> (q.fin && q.st == ST_STOP))
    else $error("queue end not flagged");

  chk_restart_pend: assert property ( // RL5
    (I_START_PTR_WE && q.st == ST_SHIFT) |=> (q.pend && q.wptr == $past(q.wptr)))
    else $error("start write disturbed transfer");

  chk_slave_no_cs: assert property ( // RL8
    !I_MASTER_SELECT |=> (O_PCS_OE == 4'h0 && O_SCK_OE == 1'b0))
    else $error("slave drove chip select");

  chk_mode_fault: assert property ( // RL9
    (master && !ssn_f && I_MASTER_SELECT) |=> (O_MODE_FAULT_FLAG ##1 O_SCK_OE))
    else $error("mode fault missing or drivers off");

  chk_open_drain: assert property ( // RL13
    I_OPEN_DRAIN_SELECT |=> (O_SCK_OUT == 1'b0 && O_MOSI_OUT == 1'b0
                             && O_MISO_OUT == 1'b0 && O_PCS_OUT == 4'h0))
    else $error("open drain pin driven high");

  chk_baud_idle: assert property ( // RL15
    (I_MASTER_SELECT && I_BAUD_DIVIDER < BAUD_MIN && q.st != ST_IDLE)
    |=> $stable(q.sck_lvl))
    else $error("serial clock moved with divider off");

  chk_rx_upper: assert property ( // RL22
    q.st == ST_DONE |=> ((q.rx[$past(q.wptr)] >> $past(q.len)) == 16'h0000))
    else $error("receive upper bits not zero");

  chk_tx_hold: assert property ( // RL24
    (q.st == ST_SHIFT && $past(q.st) == ST_SHIFT) |-> $stable(q.tx_word))
    else $error("transmit word changed mid transfer");

  cov_master_fin: cover property (master ##1 q.fin && q.st == ST_STOP);
  cov_slave_xfer: cover property (!I_MASTER_SELECT && q.st == ST_DONE);
  cov_mode_fault: cover property ($rose(O_MODE_FAULT_FLAG));
  cov_wrap: cover property (I_WRAP_ENABLE && q.st == ST_DONE && q.wptr == q.end_ptr);

endmodule

// [include/qspm_pkg.sv]
// Purpose: shared constants, state enum and helpers of the queued serial port
// Assumes: one 250 MHz system clock, synchronous active-low reset
// Notes:   command byte layout and idle levels are fixed here

package qspm_pkg;

  // clock period in ns, for reference
  localparam int CLK_PERIOD_NS = 4;

  // queue geometry
  localparam int QDEPTH  = 16;
  localparam int PTR_W   = 4;
  localparam int WORD_W  = 16;
  localparam int CMD_W   = 8;

  // command byte fields
  localparam int CMD_PCS_LSB = 0;
  localparam int CMD_PCS_W   = 4;
  localparam int CMD_LEN_SEL = 4;
  localparam int CMD_DLY_SEL = 5;

  // ram segment selects on the software port
  localparam logic [1:0] SEG_CMD = 2'h0;
  localparam logic [1:0] SEG_TX  = 2'h1;
  localparam logic [1:0] SEG_RX  = 2'h2;

  // reset and limit values
  localparam logic [3:0] PTR_RESET   = 4'h0;
  localparam logic [3:0] LEN_CODE_16 = 4'h0;
  localparam logic [4:0] LEN_DEFAULT = 5'h08;
  localparam logic [4:0] LEN_MAX     = 5'h10;
  localparam logic [7:0] BAUD_MIN    = 8'h02;
  localparam logic [6:0] DLY_MIN     = 7'h01;
  localparam logic [3:0] PCS_IDLE    = 4'hF;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_LEAD,
    ST_SHIFT,
    ST_DONE,
    ST_STOP
  } qspm_state_t;

  // length code to bit count; reserved codes fall back to eight
  function automatic logic [4:0] qspm_len_decode(input logic [3:0] code);
    logic [4:0] n;
    n = LEN_DEFAULT;
    if (code == LEN_CODE_16) begin
      n = LEN_MAX;
    end else if (code[3]) begin
      n = {2'h1, code[2:0]};
    end
    return n;
  endfunction

endpackage

// [design/qspm_pin_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clk
// Notes:   output follows only when stages two and three agree

module qspm_pin_sync #(
  parameter int              W   = 4,
  parameter logic [W-1:0]    RST = '1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // pins in, filtered out
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_filt
);

  // all synchroniser state
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } qspm_sync_t;

  qspm_sync_t q;  // registered state
  qspm_sync_t d;  // next state

  // stage one feeds only stage two
  always_comb begin
    d    = q;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.f[i] = q.s3[i];
      end
    end
  end

  // register with constant reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      q <= {RST, RST, RST, RST};
    end else begin
      q <= d;
    end
  end

  assign o_filt = q.f;

endmodule

// [bench/qspm_slave_model.sv]
// Purpose: peripheral on the far side of the serial link
// Assumes: selected while i_cs_n is low; data line pulled up when released
// Notes:   sends i_tx msb first, records received bits and clock edges
module qspm_slave_model (
  // link pins
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // setup and results
  input  wire logic        i_clock_polarity_select,
  input  wire logic        i_clock_phase_select,
  input  wire logic [15:0] i_tx,
  input  wire logic [4:0]  i_len,
  output logic      [15:0] o_rx,
  output int               o_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  int nb;  // bits driven so far
  initial o_miso = 1'b1;
  // first bit at select in phase zero
  always @(negedge i_cs_n) begin
    o_rx = '0;
    o_edges = 0;
    nb = 0;
    if (!i_clock_phase_select) begin
      o_miso = i_tx[i_len-1];
      nb = 1;
    end
  end
  // released line returns to the pull-up level
  always @(posedge i_cs_n) o_miso = 1'b1;
  // latch on one edge, drive on the other
  always @(i_sck) if (!i_cs_n) begin
    o_edges++;
    if ((i_sck != i_clock_polarity_select) ^ i_clock_phase_select) begin
      o_rx = {o_rx[14:0], i_mosi};
    end else if (nb < i_len) begin
      o_miso = i_tx[i_len-1-nb];
      nb++;
    end
  end
endmodule

// [bench/qspm_core_tb.sv]
// Purpose: self-checking bench of the queued serial port
// Assumes: model peripheral on chip select 0, pull-ups on all lines
// Notes:   random queues in all clock modes, slave, fault and stall cases
module qspm_core_tb
  import qspm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // design inputs
  logic        I_CLK = 0, I_RESETN = 0, I_PORT_ENABLE = 0, I_MASTER_SELECT = 1;
  logic        I_CLOCK_PHASE_SELECT = 0, I_CLOCK_POLARITY_SELECT = 0, I_OPEN_DRAIN_SELECT = 0;
  logic        I_WRAP_ENABLE = 0, I_QUEUE_FINISHED_IRQ_ENABLE = 0, I_SLAVE_SELECT_N = 1;
  logic        I_START_PTR_WE = 0, I_END_PTR_WE = 0, I_FLAG_CLEAR = 0, I_RAM_WE = 0;
  logic [7:0]  I_BAUD_DIVIDER = 8'h06;
  logic [3:0]  I_LENGTH_FIELD = 4'h0, I_QUEUE_START_POINTER = 4'h0, I_QUEUE_END_POINTER = 4'h0;
  logic [6:0]  I_CS_TO_CLOCK_DELAY = 7'h00;
  logic [1:0]  I_RAM_SEL = 2'h0;
  logic [3:0]  I_RAM_INDEX = 4'h0;
  logic [15:0] I_RAM_WDATA = 16'h0000;
  // design outputs
  logic [15:0] O_RAM_RDATA;
  logic [3:0]  O_QUEUE_START_POINTER, O_QUEUE_END_POINTER, O_COMPLETED_ENTRY_POINTER;
  logic [3:0]  O_PCS_OUT, O_PCS_OE;
  logic        O_QUEUE_FINISHED_FLAG, O_MODE_FAULT_FLAG, O_IRQ, O_BUSY;
  logic        O_SCK_OUT, O_SCK_OE, O_MOSI_OUT, O_MOSI_OE, O_MISO_OUT, O_MISO_OE;
  // bench state
  logic        sck_m = 1, mosi_m = 1, miso_p, sck_q, cs_q;
  logic [15:0] pat, mrx;
  logic [7:0]  cmd_sh [16];
  logic [15:0] tx_sh [16];
  logic [3:0]  cur = 4'h0;
  logic [3:0]  ent [$];
  int          medges, xfers, gap, first, runm = 0, cyc = 0, num_errors = 0, check_count = 0;
  // bits per transfer from command byte and length field
  function automatic logic [4:0] xlen(input logic [7:0] c, input logic [3:0] f);
    xlen = 5'h08;
    if (c[4] && f == 4'h0) xlen = 5'h10;
    else if (c[4] && f[3]) xlen = {2'h1, f[2:0]};
  endfunction
  // keep the low n bits
  function automatic logic [15:0] msk(input logic [15:0] w, input logic [4:0] n);
    msk = w & 16'((17'h1 << n) - 17'h1);
  endfunction
  // wire levels: released lines fall back to the pull-up or bench drive
  wire [3:0] pcs_w = (O_PCS_OE & O_PCS_OUT) | ~O_PCS_OE;
  wire sck_w = O_SCK_OE ? O_SCK_OUT : sck_m;
  wire mosi_w = O_MOSI_OE ? O_MOSI_OUT : mosi_m;
  wire miso_w = O_MISO_OE ? O_MISO_OUT : miso_p;
  wire [4:0] mlen = xlen(cmd_sh[cur], I_LENGTH_FIELD);
  qspm_core u_qspm_core (.I_CLK, .I_RESETN, .I_PORT_ENABLE, .I_MASTER_SELECT,
    .I_CLOCK_PHASE_SELECT, .I_CLOCK_POLARITY_SELECT, .I_OPEN_DRAIN_SELECT, .I_WRAP_ENABLE,
    .I_QUEUE_FINISHED_IRQ_ENABLE, .I_BAUD_DIVIDER, .I_LENGTH_FIELD, .I_CS_TO_CLOCK_DELAY,
    .I_START_PTR_WE, .I_QUEUE_START_POINTER, .I_END_PTR_WE, .I_QUEUE_END_POINTER,
    .I_FLAG_CLEAR, .I_RAM_WE, .I_RAM_SEL, .I_RAM_INDEX, .I_RAM_WDATA, .O_RAM_RDATA,
    .O_QUEUE_START_POINTER, .O_QUEUE_END_POINTER, .O_COMPLETED_ENTRY_POINTER,
    .O_QUEUE_FINISHED_FLAG, .O_MODE_FAULT_FLAG, .O_IRQ, .O_BUSY, .I_SCK_IN(sck_w),
    .O_SCK_OUT, .O_SCK_OE, .I_MOSI_IN(mosi_w), .O_MOSI_OUT, .O_MOSI_OE, .I_MISO_IN(miso_w),
    .O_MISO_OUT, .O_MISO_OE, .I_SLAVE_SELECT_N, .O_PCS_OUT, .O_PCS_OE);
  qspm_slave_model u_qspm_slave_model (.i_sck(sck_w), .i_cs_n(pcs_w[0]), .i_mosi(mosi_w),
    .o_miso(miso_p), .i_clock_polarity_select(I_CLOCK_POLARITY_SELECT), .i_clock_phase_select(I_CLOCK_PHASE_SELECT),
    .i_tx(pat), .i_len(mlen), .o_rx(mrx), .o_edges(medges));
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // clock and hang limit
  always #2 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      conclude();
    end
  end
  // link monitor: select value, edge spacing, words per transfer
  always @(posedge I_CLK) begin
    sck_q <= sck_w;
    cs_q <= pcs_w[0];
    gap <= gap + 1;
    if (runm && cs_q && !pcs_w[0]) begin
      gap <= 1;
      first <= 1;
      check(32'(pcs_w), 32'(cmd_sh[cur][3:0]));
      if (I_OPEN_DRAIN_SELECT) check(32'({O_PCS_OUT, O_MOSI_OUT}), 0);
    end else if (runm && !pcs_w[0] && sck_w !== sck_q) begin
      check(gap, !first ? I_BAUD_DIVIDER : !cmd_sh[cur][5] ? I_BAUD_DIVIDER :
            (I_CS_TO_CLOCK_DELAY == 0) ? 1 : I_CS_TO_CLOCK_DELAY);
      gap <= 1;
      first <= 0;
    end
    if (runm && !cs_q && pcs_w[0]) begin
      check(32'(mrx), 32'(msk(tx_sh[cur], mlen)));
      check(medges, 2 * mlen);
      xfers++;
      void'(ent.pop_front());
      if (ent.size() > 0) cur <= ent[0];
    end
  end
  // drive phase: 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic ptrs(input logic [3:0] s, input logic [3:0] e);
    {I_START_PTR_WE, I_QUEUE_START_POINTER} = {1'b1, s};
    {I_END_PTR_WE, I_QUEUE_END_POINTER}     = {1'b1, e};
    tick(1);
    {I_START_PTR_WE, I_END_PTR_WE} = 2'b00;
  endtask
  task automatic clear_flags;
    I_FLAG_CLEAR = 1;
    tick(1);
    I_FLAG_CLEAR = 0;
  endtask
  task automatic ram_wr(input logic [1:0] s, input logic [3:0] i, input logic [15:0] d);
    {I_RAM_WE, I_RAM_SEL, I_RAM_INDEX, I_RAM_WDATA} = {1'b1, s, i, d};
    tick(1);
    I_RAM_WE = 0;
    tick(1);
  endtask
  task automatic ram_chk(input logic [1:0] s, input logic [3:0] i, input logic [15:0] d);
    {I_RAM_SEL, I_RAM_INDEX} = {s, i};
    tick(2);
    check(32'(O_RAM_RDATA), 32'(d));
  endtask
  task automatic wait_flag;
    for (int i = 0; i < 20000 && O_QUEUE_FINISHED_FLAG !== 1'b1; i++) tick(1);
  endtask
  task automatic fill(input int s, input int e);
    for (int i = s; i <= e; i++) begin
      cmd_sh[i] = {2'h0, 2'($urandom), 3'($urandom), 1'b0};
      tx_sh[i] = 16'($urandom);
      ram_wr(SEG_CMD, 4'(i), {8'h00, cmd_sh[i]});
      ram_wr(SEG_TX, 4'(i), tx_sh[i]);
    end
  endtask
  // master queue s..e; k other than s+1 rewrites the start during entry s
  task automatic run(input int s, input int e, input int k);
    ent = {4'(s)};
    for (int i = k; i <= e; i++) ent.push_back(4'(i));
    {cur, xfers, runm} = {4'(s), 32'd0, 32'd1};
    ptrs(4'(s), 4'(e));
    I_PORT_ENABLE = 1;
    if (k != s + 1) begin
      tick(20);
      ptrs(4'(k), 4'(e));
    end
    wait_flag();
    tick(2);
    check(32'(O_COMPLETED_ENTRY_POINTER), e);
    check(xfers, e - k + 2);
    check(32'({O_BUSY, O_IRQ}), 0);
    {I_PORT_ENABLE, runm} = {1'b0, 32'd0};
    for (int i = s; i <= e; i++) if (i == s || i >= k)
      ram_chk(SEG_RX, 4'(i), msk(pat, xlen(cmd_sh[i], I_LENGTH_FIELD)));
    clear_flags();
  endtask
  // bench acts as external master in slave mode, phase zero polarity zero
  task automatic slave_xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    I_SLAVE_SELECT_N = 0;
    tick(12);
    for (int i = n - 1; i >= 0; i--) begin
      mosi_m = w[i];
      tick(10);
      r = {r[14:0], miso_w};
      sck_m = 1;
      tick(10);
      sck_m = 0;
    end
    tick(10);
    I_SLAVE_SELECT_N = 1;
    tick(10);
  endtask
  initial begin
    logic [15:0] r;
    void'($urandom(81));
    tick(4);
    I_RESETN = 1;
    tick(1);
    check(32'({O_QUEUE_START_POINTER, O_QUEUE_END_POINTER, O_COMPLETED_ENTRY_POINTER}), 0);
    check(32'({O_QUEUE_FINISHED_FLAG, O_MODE_FAULT_FLAG}), 0);
    $display("test reset done");
    // every length code on a single zero-pointer entry
    for (int c = 0; c < 16; c++) begin
      I_LENGTH_FIELD = 4'(c);
      cmd_sh[0] = 8'h1E;
      ram_wr(SEG_CMD, 4'h0, 16'h001E);
      pat = 16'($urandom);
      run(0, 0, 1);
    end
    $display("test length codes done");
    // random queues in all four clock modes, last one open drain
    for (int m = 0; m < 4; m++) begin
      int s, e;
      s = $urandom_range(0, 15);
      e = $urandom_range(s, 15);
      {I_CLOCK_POLARITY_SELECT, I_CLOCK_PHASE_SELECT} = 2'(m);
      I_OPEN_DRAIN_SELECT = (m == 3);
      I_BAUD_DIVIDER = 8'($urandom_range(6, 10));
      I_LENGTH_FIELD = 4'($urandom);
      I_CS_TO_CLOCK_DELAY = 7'($urandom_range(5, 20));
      pat = 16'($urandom);
      fill(s, e);
      tick(6);
      run(s, e, s + 1);
      $display("test master mode %0d done", m);
    end
    {I_CLOCK_POLARITY_SELECT, I_CLOCK_PHASE_SELECT, I_OPEN_DRAIN_SELECT} = 3'b000;
    tick(6);
    fill(0, 3);
    run(0, 3, 2);
    $display("test start rewrite done");
    // stalled divider, then select input pulled in master mode
    for (int b = 0; b < 2; b++) begin
      I_BAUD_DIVIDER = 8'(b);
      I_PORT_ENABLE = 1;
      tick(200);
      check(32'({sck_w, O_BUSY, O_QUEUE_FINISHED_FLAG}), 32'h2);
      check(medges, 0);
      I_SLAVE_SELECT_N = 0;
      tick(10);
      I_SLAVE_SELECT_N = 1;
      tick(6);
      check(32'({O_MODE_FAULT_FLAG, O_SCK_OE}), 32'h3);
      clear_flags();
      I_PORT_ENABLE = 0;
      tick(1);
      check(32'(O_MODE_FAULT_FLAG), 0);
    end
    $display("test stall and fault done");
    // wraparound keeps running and raises the request each lap
    {I_BAUD_DIVIDER, I_WRAP_ENABLE, I_QUEUE_FINISHED_IRQ_ENABLE} = {8'h06, 2'b11};
    fill(1, 2);
    ptrs(1, 2);
    I_PORT_ENABLE = 1;
    wait_flag();
    check(32'(O_IRQ), 1);
    clear_flags();
    wait_flag();
    check(32'({O_BUSY, O_QUEUE_FINISHED_FLAG}), 32'h3);
    {I_PORT_ENABLE, I_WRAP_ENABLE, I_QUEUE_FINISHED_IRQ_ENABLE} = 3'b000;
    clear_flags();
    $display("test wraparound done");
    // slave mode, twelve-bit words from the length field
    {I_MASTER_SELECT, I_LENGTH_FIELD, sck_m} = {1'b0, 4'hC, 1'b0};
    tx_sh[4] = 16'($urandom);
    ram_wr(SEG_TX, 4'h4, tx_sh[4]);
    ptrs(4, 5);
    I_PORT_ENABLE = 1;
    tick(6);
    pat = 16'($urandom);
    slave_xfer(pat, 12, r);
    check(32'(r), 32'(msk(tx_sh[4], 5'd12)));
    check(32'({O_COMPLETED_ENTRY_POINTER, O_PCS_OE}), 32'h40);
    ram_chk(SEG_RX, 4'h4, msk(pat, 5'd12));
    ram_wr(SEG_RX, 4'h4, ~pat);
    ram_chk(SEG_RX, 4'h4, msk(pat, 5'd12));
    ram_chk(2'h3, 4'h0, 16'h0000);
    I_PORT_ENABLE = 0;
    $display("test slave done");
    conclude();
  end
endmodule
